// >>> hdl/sewe_device.sv
/*
  Memory end: two-wire slave with 8192-byte array, page buffer and timed programming.
  Assumes bus lines come through sewe_if; the array is flip-flops for simulation.
*/
`timescale 1ns/1ps
module sewe_device
  import sewe_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  sewe_if.device bus,
  input wire logic address_select_pin_0,
  input wire logic address_select_pin_1,
  input wire logic address_select_pin_2,
  input wire logic write_protect,
  output logic busy,
  output logic standby
);
  typedef enum logic [5:0] {
    SEWE_IDLE = 6'b000001, SEWE_DEVADR = 6'b000010, SEWE_ADRHI = 6'b000100,
    SEWE_ADRLO = 6'b001000, SEWE_WDATA = 6'b010000, SEWE_RDATA = 6'b100000
  } sewe_dst_e;
  logic scl_s, sda_s, scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  sewe_dst_e st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic ack_phase_q, ack_drive_q, master_nack_q, rd_q;
  logic [12:0] addr_q;
  logic [7:0] mem_q [SEWE_MEM_DEPTH];
  logic [7:0] page_q [128];
  logic [127:0] pvalid_q;
  logic [5:0] pgbase_q;
  logic [31:0] prog_q;
  logic pending_q;
  logic [7:0] rd_byte;
  logic wp_s;
  logic [2:0] sel_s;

  sewe_sync u_scl (.clk(clk), .rst_n(rst_n), .din(bus.scl), .dout(scl_s));
  sewe_sync u_sda (.clk(clk), .rst_n(rst_n), .din(bus.sda), .dout(sda_s));
  // Strap and protect pins are asynchronous too; protect reads high for two cycles
  sewe_sync u_wp (.clk(clk), .rst_n(rst_n), .din(write_protect), .dout(wp_s));
  sewe_sync u_sel0 (.clk(clk), .rst_n(rst_n), .din(address_select_pin_0), .dout(sel_s[0]));
  sewe_sync u_sel1 (.clk(clk), .rst_n(rst_n), .din(address_select_pin_1), .dout(sel_s[1]));
  sewe_sync u_sel2 (.clk(clk), .rst_n(rst_n), .din(address_select_pin_2), .dout(sel_s[2]));

  ////////////////////////////////////////////////////////////////////////
  // Edge and condition detection on synchronised lines
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign rd_byte = mem_q[addr_q];

  ////////////////////////////////////////////////////////////////////////
  // Protocol engine; one bit per clock pulse
  // sample and shift on rise, drive on fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= SEWE_IDLE;
      bit_q <= 4'h0;
      sh_q <= SEWE_BYTE_RST;
      ack_phase_q <= 1'b0;
      ack_drive_q <= 1'b0;
      master_nack_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= SEWE_ADDR_RST;
      pending_q <= 1'b0;
      pvalid_q <= '0;
      pgbase_q <= 6'h00;
    end else if (busy) begin
      st_q <= SEWE_IDLE;
      ack_drive_q <= 1'b0;
      pending_q <= 1'b0;
    end else if (start_ev) begin
      st_q <= SEWE_DEVADR;
      bit_q <= 4'h0;
      ack_phase_q <= 1'b0;
      ack_drive_q <= 1'b0;
    end else if (stop_ev) begin
      st_q <= SEWE_IDLE;
      ack_drive_q <= 1'b0;
      pending_q <= 1'b0;
    end else if (st_q != SEWE_IDLE) begin
      if (scl_rise && !ack_phase_q) begin
        sh_q <= {sh_q[6:0], sda_s};
        bit_q <= bit_q + 4'h1;
      end else if (scl_rise && ack_phase_q && st_q == SEWE_RDATA) begin
        master_nack_q <= sda_s;
      end
      if (scl_fall && ack_phase_q) begin
        ack_phase_q <= 1'b0;
        ack_drive_q <= 1'b0;
        bit_q <= 4'h0;
        if (st_q == SEWE_RDATA) begin
          if (master_nack_q) begin
            st_q <= SEWE_IDLE;
          end else begin
            sh_q <= rd_byte;
            ack_drive_q <= ~rd_byte[7];
          end
        end else if (rd_q && st_q == SEWE_WDATA) begin
          st_q <= SEWE_RDATA;
          sh_q <= rd_byte;
          ack_drive_q <= ~rd_byte[7];
        end
      end else if (scl_fall && bit_q == SEWE_BIT_LAST) begin
        ack_phase_q <= 1'b1;
        ack_drive_q <= 1'b0;
        unique case (st_q)
          SEWE_DEVADR: begin
            if (sh_q[7:4] == SEWE_TYPE_CODE && sh_q[3:1] == sel_s) begin
              ack_drive_q <= 1'b1;
              rd_q <= sh_q[0];
              st_q <= sh_q[0] ? SEWE_WDATA : SEWE_ADRHI;
            end else begin
              st_q <= SEWE_IDLE;
              ack_phase_q <= 1'b0;
            end
          end
          SEWE_ADRHI: begin
            addr_q[12:8] <= sh_q[4:0];
            ack_drive_q <= 1'b1;
            st_q <= SEWE_ADRLO;
          end
          SEWE_ADRLO: begin
            addr_q[7:0] <= sh_q;
            ack_drive_q <= 1'b1;
            // Page number from the new high byte and this byte's top bit
            pgbase_q <= {addr_q[12:8], sh_q[7]};
            // Fresh page: marks of the last write were used by its commit
            pvalid_q <= '0;
            st_q <= SEWE_WDATA;
          end
          SEWE_WDATA: begin
            ack_drive_q <= 1'b1;
            pvalid_q[addr_q[6:0]] <= 1'b1;
            pending_q <= ~wp_s;
            addr_q[6:0] <= addr_q[6:0] + 7'h01;
          end
          SEWE_RDATA: begin
            addr_q <= addr_q + 13'h0001;
          end
          default: st_q <= SEWE_IDLE;
        endcase
      end else if (scl_fall && st_q == SEWE_RDATA) begin
        // The rise already shifted, so the next bit sits at the top
        ack_drive_q <= ~sh_q[7];
      end
    end
  end

  // Data byte capture into page buffer
  always_ff @(posedge clk) begin
    if (!busy && !start_ev && !stop_ev && scl_fall && !ack_phase_q &&
        bit_q == SEWE_BIT_LAST && st_q == SEWE_WDATA) begin
      page_q[addr_q[6:0]] <= sh_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Self-timed programming; whole page in one cycle
  // programming begins at Stop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_q <= 32'h0000_0000;
      busy <= 1'b0;
    end else if (!busy && stop_ev && pending_q) begin
      prog_q <= 32'(SEWE_PROG_CYC);
      busy <= 1'b1;
    end else if (busy) begin
      prog_q <= prog_q - 32'h0000_0001;
      busy <= (prog_q > 32'h0000_0001);
    end
  end

  always_ff @(posedge clk) begin
    if (busy && prog_q == 32'h0000_0001) begin
      for (int i = 0; i < 128; i++) begin
        if (pvalid_q[i]) begin
          mem_q[{pgbase_q, 7'(i)}] <= page_q[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.sda_s_oe <= 1'b0;
      standby <= 1'b1;
    end else begin
      bus.sda_s_oe <= ack_drive_q & ~busy;
      // standby when idle and not programming
      standby <= (st_q == SEWE_IDLE) & ~busy;
    end
  end
endmodule : sewe_device

// >>> hdl/sewe_pkg.sv
/*
  Constants shared by both ends of the two-wire serial memory link.
  Assumes a 40 MHz system clock at each end; the bus lines are sampled.
*/
// How it works
// - Start is data falling, clock high.
// - Stop is data rising, clock high.
// - Data changes only with clock low.
// - Device ignores bus until Start.
// - Receiver acknowledges on the ninth clock.
// - Master recovers with nine clocks then Start; sewe_master has no such sequence.
// - Address: fixed type code plus three select pins.
// - Direction bit: one read, zero write.
// - Byte write programs at Stop.
// - Busy device ignores and never acknowledges.
// - Page write takes up to 128 bytes.
// - Only seven low address bits increment.
// - Over 128 bytes overwrite earlier page data.
// - Page programmed once, inputs off meanwhile.
// - Acknowledge polling: no ack while busy.
// - Current read returns counter location.
// - Reads wrap array, writes wrap page.
// - Master ends read with no-ack, Stop.
// - Random read: dummy write, repeated Start.
// - Sequential read continues on each master ack.
// - Read wraps from top to zero.
// - Standby after power-up, reads, write cycles.
// - Write-protect high blocks all array writes; the code takes it at each data byte, so the last byte before Stop decides.
package sewe_pkg;
  localparam int unsigned SEWE_MEM_DEPTH = 8192;
  localparam int unsigned SEWE_ADDR_W = 13;
  localparam int unsigned SEWE_PAGE_W = 7;
  // Type code is arbitrary, not any maker's code
  localparam logic [3:0] SEWE_TYPE_CODE = 4'h5;
  localparam logic [12:0] SEWE_ADDR_RST = 13'h0000;
  localparam logic [7:0] SEWE_BYTE_RST = 8'h00;
  localparam logic [3:0] SEWE_BIT_LAST = 4'h8;
  localparam int unsigned SEWE_CLK_MHZ = 40;
  localparam int unsigned SEWE_PROG_US = 5;
  localparam int unsigned SEWE_PROG_CYC = SEWE_PROG_US * SEWE_CLK_MHZ;
  localparam int unsigned SEWE_HALF_NS = 1250;
  localparam int unsigned SEWE_HALF_CYC = SEWE_HALF_NS / 25;
  localparam logic [3:0] SEWE_RECOVER_CLKS = 4'h9;
endpackage : sewe_pkg

// >>> hdl/sewe_if.sv
/*
  Two-wire bus carrier joining master and memory ends.
  Assumes both ends drive open-drain style: an enable pulls the line low.
*/
`timescale 1ns/1ps
interface sewe_if;
  logic scl_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Wired-AND with pull-ups
  assign scl = ~scl_oe;
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport master (input scl, input sda, output scl_oe, output sda_m_oe);
  modport device (input scl, input sda, output sda_s_oe);
endinterface : sewe_if

// >>> hdl/sewe_sync.sv
/*
  Two-flop synchroniser for one bus line.
  Assumes din is asynchronous to clk.
*/
`timescale 1ns/1ps
module sewe_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  // Idle bus level is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : sewe_sync

// >>> hdl/sewe_master.sv
/*
  Master end: issues single transactions on the two-wire bus.
  Assumes a user pulses cmd_valid with a command word while ready is high.
*/
`timescale 1ns/1ps
module sewe_master
  import sewe_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  sewe_if.master bus,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_last,
  output logic ready,
  output logic [7:0] rsp_byte,
  output logic rsp_ack,
  output logic rsp_valid
);
  // cmd_kind: 0 Start+byte, 1 write byte, 2 read byte (ack unless cmd_last), 3 Stop
  typedef enum logic [3:0] {
    SEWM_IDLE = 4'b0001, SEWM_START = 4'b0010, SEWM_BITS = 4'b0100, SEWM_STOP = 4'b1000
  } sewm_st_e;
  sewm_st_e st_q;
  logic scl_s, sda_s;
  logic [7:0] cnt_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic rd_q, last_q;

  sewe_sync u_scl (.clk(clk), .rst_n(rst_n), .din(bus.scl), .dout(scl_s));
  sewe_sync u_sda (.clk(clk), .rst_n(rst_n), .din(bus.sda), .dout(sda_s));

  ////////////////////////////////////////////////////////////////////////
  // Clock divider phases: low1, low2 with data set, high, high-sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= SEWM_IDLE;
      cnt_q <= 8'h00;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      last_q <= 1'b0;
      ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_byte <= 8'h00;
      rsp_ack <= 1'b0;
      bus.scl_oe <= 1'b0;
      bus.sda_m_oe <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (st_q != SEWM_IDLE) begin
        cnt_q <= cnt_q + 8'h01;
      end
      unique case (st_q)
        SEWM_IDLE: begin
          if (cmd_valid) begin
            ready <= 1'b0;
            cnt_q <= 8'h00;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            sh_q <= cmd_byte;
            rd_q <= (cmd_kind == 2'd2);
            last_q <= cmd_last;
            st_q <= (cmd_kind == 2'd0) ? SEWM_START :
                    (cmd_kind == 2'd3) ? SEWM_STOP : SEWM_BITS;
            if (cmd_kind == 2'd0 || cmd_kind == 2'd3) begin
              bus.sda_m_oe <= (cmd_kind == 2'd3);
            end
          end
        end
        SEWM_START: begin
          if (cnt_q == 8'(SEWE_HALF_CYC)) begin
            bus.scl_oe <= 1'b0;
          end else if (cnt_q == 8'(2 * SEWE_HALF_CYC)) begin
            bus.sda_m_oe <= 1'b1;
          end else if (cnt_q == 8'(3 * SEWE_HALF_CYC)) begin
            bus.scl_oe <= 1'b1;
            cnt_q <= 8'h00;
            st_q <= SEWM_BITS;
          end
        end
        SEWM_STOP: begin
          if (cnt_q == 8'(SEWE_HALF_CYC)) begin
            bus.scl_oe <= 1'b0;
          end else if (cnt_q == 8'(2 * SEWE_HALF_CYC)) begin
            bus.sda_m_oe <= 1'b0;
          end else if (cnt_q == 8'(3 * SEWE_HALF_CYC)) begin
            st_q <= SEWM_IDLE;
            ready <= 1'b1;
          end
        end
        SEWM_BITS: begin
          if (cnt_q == 8'(SEWE_HALF_CYC / 2)) begin
            // master no-ack on last read byte
            if (bit_q == SEWE_BIT_LAST) begin
              bus.sda_m_oe <= rd_q & ~last_q;
            end else begin
              bus.sda_m_oe <= ~rd_q & ~sh_q[7];
            end
          end else if (cnt_q == 8'(SEWE_HALF_CYC)) begin
            bus.scl_oe <= 1'b0;
          end else if (cnt_q == 8'(3 * SEWE_HALF_CYC / 2)) begin
            if (bit_q == SEWE_BIT_LAST) begin
              rsp_ack <= ~sda_s;
            end else begin
              sh_q <= {sh_q[6:0], sda_s};
            end
          end else if (cnt_q == 8'(2 * SEWE_HALF_CYC)) begin
            bus.scl_oe <= 1'b1;
            cnt_q <= 8'h00;
            if (bit_q == SEWE_BIT_LAST) begin
              bus.sda_m_oe <= 1'b0;
              rsp_byte <= sh_q;
              rsp_valid <= 1'b1;
              ready <= 1'b1;
              st_q <= SEWM_IDLE;
            end else begin
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        default: st_q <= SEWM_IDLE;
      endcase
    end
  end
endmodule : sewe_master

// >>> dv/sewe_assertions.sv
/*
  Checker on the two-wire bus between master and memory ends.
  Assumes the bus lines are seen as plain inputs on the bench clock.
*/
`timescale 1ns/1ps
module sewe_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe
);
  logic scl_q, sda_q, open_q, st, sp, rise;
  logic [3:0] nrise_q, mod_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Start and stop seen in the cycle data changes, clock high on both samples, so no clock edge fakes one
  assign st = scl && scl_q && sda_q && !sda;
  assign sp = scl && scl_q && !sda_q && sda;
  assign rise = scl && !scl_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // Transfer open from start to stop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) open_q <= 1'b0;
    else if (st) open_q <= 1'b1;
    else if (sp) open_q <= 1'b0;
  end
  // Clock rises since start, saturating so long reads stay quiet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) nrise_q <= 4'hf;
    else if (st) nrise_q <= 4'h0;
    else if (rise && nrise_q != 4'hf) nrise_q <= nrise_q + 4'h1;
  end
  // Rises modulo nine: one byte plus its acknowledge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mod_q <= 4'h0;
    else if (st) mod_q <= 4'h0;
    else if (rise) mod_q <= (mod_q == 4'h8) ? 4'h0 : mod_q + 4'h1;
  end
  ////////////////////////////////////////
  property p_clock_only_open; $fell(scl) |-> open_q; endproperty
  a_clock_only_open: assert property (p_clock_only_open)
    else $error("clock pulsed outside a transfer");
  property p_clock_after_start; st |-> ##[1:300] !scl; endproperty
  a_clock_after_start: assert property (p_clock_after_start)
    else $error("no clock after start");
  property p_stop_release; sp |-> !sda_s_oe [*8]; endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("memory drives data after stop");
  property p_change_low; $changed(sda_s_oe) |-> !scl; endproperty
  a_change_low: assert property (p_change_low)
    else $error("memory changed data with clock high");
  property p_idle_quiet; !open_q |-> !sda_s_oe; endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("memory drove the idle bus");
  property p_bit_held; $rose(scl) && sda_s_oe |-> sda_s_oe [*8]; endproperty
  a_bit_held: assert property (p_bit_held)
    else $error("memory bit not held over clock high");
  property p_frame_nine; sp || (st && open_q) |-> mod_q == 4'h1; endproperty
  a_frame_nine: assert property (p_frame_nine)
    else $error("transfer not whole bytes with acknowledge");
  property p_addr_silent; open_q && nrise_q < 4'h8 |-> !sda_s_oe; endproperty
  a_addr_silent: assert property (p_addr_silent)
    else $error("memory drove during slave address");
  property p_lines_free; !open_q && !st |-> !scl_oe && !sda_m_oe; endproperty
  a_lines_free: assert property (p_lines_free)
    else $error("master held a line between transfers");
  c_start: cover property (st && !open_q);
  c_restart: cover property (st && open_q);
  c_ack: cover property ($rose(scl) && sda_s_oe && nrise_q == 4'h8);
endmodule : sewe_assertions

// >>> dv/serial_eeprom_two_wire_slave_test.sv
/*
  Self-checking bench: master end and memory end joined by the bus carrier.
  Assumes the 40 MHz clock and the constants of sewe_pkg.
*/
`timescale 1ns/1ps
module serial_eeprom_two_wire_slave_test
  import sewe_pkg::*;
;
  logic clk, rst_n, cmd_valid, cmd_last, ready, rsp_ack, rsp_valid, wp, busy, standby;
  logic [1:0] cmd_kind;
  logic [7:0] cmd_byte, rsp_byte;
  logic [2:0] sel;
  logic [7:0] mem_m [0:8191];
  logic [7:0] wd [0:3];
  logic [12:0] ptr, a;
  int bad_count, checks, seed;
  sewe_if bus ();
  sewe_master u_sewe_master (.clk(clk), .rst_n(rst_n), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_byte(cmd_byte), .cmd_last(cmd_last), .ready(ready),
    .rsp_byte(rsp_byte), .rsp_ack(rsp_ack), .rsp_valid(rsp_valid));
  sewe_device u_sewe_device (.clk(clk), .rst_n(rst_n), .bus(bus),
    .address_select_pin_0(sel[0]), .address_select_pin_1(sel[1]),
    .address_select_pin_2(sel[2]), .write_protect(wp), .busy(busy), .standby(standby));
  sewe_assertions u_sewe_assertions (.clk(clk), .rst_n(rst_n), .scl(bus.scl), .sda(bus.sda),
    .scl_oe(bus.scl_oe), .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe));
  ////////////////////////////////////////
  // Clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check
  // One command, held until taken, then wait for byte or stop to finish
  task automatic cmd(input logic [1:0] k, input logic [7:0] b, input logic l);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_byte <= b;
    cmd_last <= l;
    do @(posedge clk); while (ready !== 1'b1);
    cmd_valid <= 1'b0;
    do @(posedge clk); while (k == 2'd3 ? ready !== 1'b1 : rsp_valid !== 1'b1);
  endtask : cmd
  // Next address during a write: low seven bits wrap inside the page
  function automatic logic [12:0] in_page_next(input logic [12:0] ad);
    return {ad[12:7], ad[6:0] + 7'h01};
  endfunction : in_page_next
  // Start, slave address and two address bytes
  task automatic head(input logic [12:0] ad);
    cmd(2'd0, {SEWE_TYPE_CODE, sel, 1'b0}, 1'b0);
    check(8'(rsp_ack), 8'h01, "addr ack");
    cmd(2'd1, {3'h0, ad[12:8]}, 1'b0);
    cmd(2'd1, ad[7:0], 1'b0);
    check(8'(rsp_ack), 8'h01, "low ack");
  endtask : head
  // Page write of n bytes; address wraps inside the page
  task automatic wr(input logic [12:0] ad, input int n);
    int w;
    head(ad);
    for (int i = 0; i < n; i++) begin
      cmd(2'd1, wd[i], 1'b0);
      check(8'(rsp_ack), 8'h01, "data ack");
      if (!wp) mem_m[ad] = wd[i];
      ad = in_page_next(ad);
    end
    cmd(2'd3, 8'h00, 1'b0);
    w = 0;
    while (busy !== 1'b1 && w < 20) begin
      @(posedge clk);
      w++;
    end
    check(8'(busy), 8'(!wp), "busy at stop");
    // Poll at once: its Start lands inside programming unless the write was blocked
    cmd(2'd0, {SEWE_TYPE_CODE, sel, 1'b0}, 1'b0);
    check(8'(rsp_ack), 8'(wp), "poll while busy");
    cmd(2'd3, 8'h00, 1'b0);
    while (busy !== 1'b0 && w < 400) begin
      @(posedge clk);
      w++;
    end
    // Standby trails busy by one register stage
    @(posedge clk);
    check(8'(standby), 8'h01, "standby");
    cmd(2'd0, {SEWE_TYPE_CODE, sel, 1'b0}, 1'b0);
    check(8'(rsp_ack), 8'h01, "poll ack");
    cmd(2'd3, 8'h00, 1'b0);
  endtask : wr
  // Random read via dummy write, or current read; n bytes in sequence
  task automatic rd(input logic [12:0] ad, input int n, input logic cur);
    if (!cur) begin
      // dummy write loads the counter, then a repeated Start
      head(ad);
      ptr = ad;
    end
    cmd(2'd0, {SEWE_TYPE_CODE, sel, 1'b1}, 1'b0);
    check(8'(rsp_ack), 8'h01, "read ack");
    for (int i = 0; i < n; i++) begin
      cmd(2'd2, 8'h00, i == n - 1);
      check(rsp_byte, mem_m[ptr], "read data");
      ptr = ptr + 13'h0001;
    end
    cmd(2'd3, 8'h00, 1'b0);
  endtask : rd
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////
  // Watchdog well above the expected run of about 77k cycles
  initial begin
    repeat (98000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  initial begin
    seed = 32'h499bb590;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = 2'd0;
    cmd_byte = 8'h00;
    cmd_last = 1'b0;
    wp = 1'b0;
    sel = 3'($random(seed));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(8'(standby), 8'h01, "standby after reset");
    // wrong select bits, then wrong type code, both ignored
    cmd(2'd0, {SEWE_TYPE_CODE, ~sel, 1'b0}, 1'b0);
    check(8'(rsp_ack), 8'h00, "foreign select");
    // a fresh Start restarts the interface after a refused byte
    cmd(2'd0, {~SEWE_TYPE_CODE, sel, 1'b1}, 1'b0);
    check(8'(rsp_ack), 8'h00, "foreign type");
    cmd(2'd3, 8'h00, 1'b0);
    $display("test address done");
    // write across page end, read back with wrap and current read
    for (int t = 0; t < 2; t++) begin
      a = {6'($random(seed)), 7'h7e};
      for (int j = 0; j < 4; j++) wd[j] = 8'($random(seed));
      wr(a, 4);
      rd(a, 2, 1'b0);
      rd({a[12:7], 7'h00}, 1, 1'b0);
      rd(13'h0000, 1, 1'b1);
      $display("test page wrap %0d done", t);
    end
    // sequential read rolls from top to zero
    wd[0] = 8'($random(seed));
    wr(13'h1fff, 1);
    wd[0] = 8'($random(seed));
    wr(13'h0000, 1);
    rd(13'h1fff, 2, 1'b0);
    $display("test array wrap done");
    wp <= 1'b1;
    wd[0] = ~mem_m[13'h1fff];
    wr(13'h1fff, 1);
    wp <= 1'b0;
    rd(13'h1fff, 1, 1'b0);
    $display("test protect done");
    complete_run();
  end
endmodule : serial_eeprom_two_wire_slave_test
